// ===== tpcp_cond_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tpcp_cond_if #(
	parameter int INPUT_COUNT = 5
);
	logic [INPUT_COUNT-1:0] raw;
	logic [INPUT_COUNT-1:0] polarity;
	logic [tpcp_pkg::TRIG_SEL_WIDTH-1:0] trig_sel;
	logic [INPUT_COUNT-1:0] active;
	logic count_pulse;

	modport cond (input raw, input polarity, input trig_sel, output active, output count_pulse);
	modport core (output raw, output polarity, output trig_sel, input active, input count_pulse);
endinterface : tpcp_cond_if
`default_nettype wire

// ===== tpcp_contacts.sv
`timescale 1ns/1ps
`default_nettype none
module tpcp_contacts (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [2:0] i_sel,
	input wire logic [4:0] i_pol,
	input wire logic [4:0] i_rest,
	output logic [4:0] o_raw
);
	int phase = 0;
	// Two cycles active, then at least three inactive before the next pulse may start
	always @(posedge i_clk) begin
		if (phase != 0) phase <= (phase + 1) % 5;
		else if (i_go) phase <= 1;
	end
	// Active contact state equals the polarity bit: closed if positive, open if negative
	always_comb begin
		o_raw = i_rest;
		if (phase == 1 || phase == 2) o_raw[i_sel] = i_pol[i_sel];
	end
endmodule : tpcp_contacts
`default_nettype wire

// ===== tpcp_input_cond.sv
`timescale 1ns/1ps
`default_nettype none
module tpcp_input_cond #(
	parameter int INPUT_COUNT = 5
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	tpcp_cond_if.cond bus
);
	typedef struct packed {
		logic [INPUT_COUNT-1:0] active;
		logic prev;
		logic pulse;
	} tpcp_cond_state_type;

	tpcp_cond_state_type st;
	tpcp_cond_state_type next_st;
	logic trig_cur;

	// Unassigned select codes give no trigger
	assign trig_cur = (32'(bus.trig_sel) < INPUT_COUNT) ? st.active[bus.trig_sel] : 1'b0;

	always_comb begin
		next_st = st;
		// Bit i of the polarity word governs input i
		next_st.active = ~(bus.raw ^ bus.polarity); // [RULE_04] [RULE_05] [RULE_06] [RULE_07]
		next_st.prev = trig_cur;
		next_st.pulse = trig_cur && !st.prev; // [RULE_02]
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign bus.active = st.active;
	assign bus.count_pulse = st.pulse;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_pol_positive: assert property (1'b1 |=> ((bus.active & $past(bus.polarity)) == // [RULE_05]
		($past(bus.raw) & $past(bus.polarity)))) else $error("positive input sense wrong");
	a_pol_negative: assert property (1'b1 |=> ((bus.active & ~$past(bus.polarity)) == // [RULE_06]
		(~$past(bus.raw) & ~$past(bus.polarity)))) else $error("negative input sense wrong");
	a_neg_open_active: assert property (1'b1 |=> // [RULE_07]
		((~$past(bus.polarity) & ~$past(bus.raw) & ~bus.active) == '0))
		else $error("open input under negative sense not active");
	a_pulse_rise: assert property (bus.count_pulse |-> // [RULE_02]
		$past(trig_cur) && !$past(st.prev)) else $error("count pulse without rising trigger");
	a_pulse_single: assert property (bus.count_pulse |=> !bus.count_pulse)
		else $error("count pulse longer than one cycle");
endmodule : tpcp_input_cond
`default_nettype wire

// ===== tpcp_pkg.sv
package tpcp_pkg;

	// Avalon-MM byte address width and data width
	localparam int ADDR_WIDTH = 5;
	localparam int DATA_WIDTH = 32;
	localparam int TRIG_SEL_WIDTH = 3;
	localparam int IRQ_WIDTH = 2;

	// Register byte offsets, one aligned word each
	localparam logic [ADDR_WIDTH-1:0] OFF_HS_MODE = 5'h00;
	localparam logic [ADDR_WIDTH-1:0] OFF_SET_COUNT = 5'h04;
	localparam logic [ADDR_WIDTH-1:0] OFF_SPEC_COUNT = 5'h08;
	localparam logic [ADDR_WIDTH-1:0] OFF_POLARITY = 5'h0C;
	localparam logic [ADDR_WIDTH-1:0] OFF_TRIG_SEL = 5'h10;
	localparam logic [ADDR_WIDTH-1:0] OFF_COUNT = 5'h14;
	localparam logic [ADDR_WIDTH-1:0] OFF_IRQ_STATUS = 5'h18;
	localparam logic [ADDR_WIDTH-1:0] OFF_IRQ_MASK = 5'h1C;

	// Field positions
	localparam int ACTIVE_LSB = 16;
	localparam int IRQ_SET_BIT = 0;
	localparam int IRQ_SPEC_BIT = 1;

	// Values after reset
	localparam logic HS_MODE_RESET = 1'h0;
	localparam logic [15:0] SET_COUNT_RESET = 16'h0000;
	localparam logic [15:0] SPEC_COUNT_RESET = 16'h0000;
	localparam logic [4:0] POLARITY_RESET = 5'h1F;
	localparam logic [TRIG_SEL_WIDTH-1:0] TRIG_SEL_RESET = 3'h0;
	localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 2'h0;

	// High-speed output terminal modes
	localparam logic HS_MODE_SWITCH = 1'h0;
	localparam logic HS_MODE_PULSE = 1'h1;

endpackage : tpcp_pkg

// ===== tpcp_top.sv
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RULE_01] Mode 0 plain switch, mode 1 pulse output
// [RULE_02] Count trigger pulses, indicate at set count
// [RULE_03] Indicate from specified count until set count
// [RULE_04] Five polarity bits, lowest bit first input
// [RULE_05] Bit 1: connected is active
// [RULE_06] Bit 0: inverted, negative input sense
// [RULE_07] Negative sense: connected inactive, open active
// [RULE_08] Count restarts from zero at set count
module tpcp_top #(
	parameter int COUNT_WIDTH = 16,
	parameter int INPUT_COUNT = 5
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [tpcp_pkg::ADDR_WIDTH-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [tpcp_pkg::DATA_WIDTH-1:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [tpcp_pkg::DATA_WIDTH-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [INPUT_COUNT-1:0] i_digital_input,
	output logic o_first_switch_output,
	output logic o_high_speed_output_terminal,
	output logic o_irq
);
	typedef struct packed {
		logic hs_mode;
		logic [COUNT_WIDTH-1:0] set_count;
		logic [COUNT_WIDTH-1:0] spec_count;
		logic [INPUT_COUNT-1:0] polarity;
		logic [tpcp_pkg::TRIG_SEL_WIDTH-1:0] trig_sel;
		logic [COUNT_WIDTH-1:0] count;
		logic set_ind;
		logic spec_ind;
		logic hs_out;
		logic [tpcp_pkg::IRQ_WIDTH-1:0] irq_status;
		logic [tpcp_pkg::IRQ_WIDTH-1:0] irq_mask;
		logic irq;
		logic waitreq;
		logic [tpcp_pkg::DATA_WIDTH-1:0] rdata;
	} tpcp_state_type;

	tpcp_state_type st;
	tpcp_state_type next_st;

	tpcp_cond_if #(.INPUT_COUNT(INPUT_COUNT)) cond_bus ();

	logic req;
	logic accept;
	logic capture;
	logic [COUNT_WIDTH-1:0] cnt_inc;
	logic set_hit;
	logic spec_hit;
	logic [tpcp_pkg::IRQ_WIDTH-1:0] events;
	logic [tpcp_pkg::IRQ_WIDTH-1:0] status_clr;

	// Byte-lane merge of a write into a register word
	function automatic logic [31:0] tpcp_merge(input logic [31:0] old_word,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] result;
		result = old_word;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				result[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return result;
	endfunction : tpcp_merge

	tpcp_input_cond #(
		.INPUT_COUNT(INPUT_COUNT)
	) u_input_cond (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.bus(cond_bus.cond)
	);

	assign cond_bus.raw = i_digital_input;
	assign cond_bus.polarity = st.polarity;
	assign cond_bus.trig_sel = st.trig_sel;

	// Bus handshake: first cycle of a request captures read data,
	// the next cycle drops waitrequest and commits the access
	assign req = i_avs_read || i_avs_write;
	assign capture = req && st.waitreq;
	assign accept = req && !st.waitreq;

	assign cnt_inc = st.count + COUNT_WIDTH'(1);
	assign set_hit = cond_bus.count_pulse && (st.set_count != '0) && (cnt_inc == st.set_count);
	assign spec_hit = cond_bus.count_pulse && (st.spec_count != '0) && (cnt_inc == st.spec_count);
	assign events = {spec_hit, set_hit};

	// Clear only what the status read reported, so later events survive
	assign status_clr = (accept && i_avs_read && i_avs_address == tpcp_pkg::OFF_IRQ_STATUS) ?
		st.rdata[tpcp_pkg::IRQ_WIDTH-1:0] : '0;

	always_comb begin
		next_st = st;

		// Pulse counter and indications
		if (cond_bus.count_pulse) begin
			if (set_hit) begin
				next_st.count = '0; // [RULE_08]
			end else begin
				next_st.count = cnt_inc; // [RULE_02]
			end
			next_st.set_ind = set_hit; // [RULE_02]
			if (spec_hit) begin
				next_st.spec_ind = 1'b1; // [RULE_03]
			end else if (st.count == '0) begin
				next_st.spec_ind = 1'b0; // [RULE_03]
			end
		end

		if (st.hs_mode == tpcp_pkg::HS_MODE_PULSE) begin
			next_st.hs_out = cond_bus.count_pulse; // [RULE_01]
		end else begin
			next_st.hs_out = next_st.spec_ind; // [RULE_01]
		end

		// Bus timing
		next_st.waitreq = !capture;
		if (capture) begin
			next_st.rdata = '0;
			if (i_avs_read) begin
				unique case (i_avs_address)
					tpcp_pkg::OFF_HS_MODE: begin
						next_st.rdata[0] = st.hs_mode;
					end
					tpcp_pkg::OFF_SET_COUNT: begin
						next_st.rdata[COUNT_WIDTH-1:0] = st.set_count;
					end
					tpcp_pkg::OFF_SPEC_COUNT: begin
						next_st.rdata[COUNT_WIDTH-1:0] = st.spec_count;
					end
					tpcp_pkg::OFF_POLARITY: begin
						next_st.rdata[INPUT_COUNT-1:0] = st.polarity;
					end
					tpcp_pkg::OFF_TRIG_SEL: begin
						next_st.rdata[tpcp_pkg::TRIG_SEL_WIDTH-1:0] = st.trig_sel;
					end
					tpcp_pkg::OFF_COUNT: begin
						next_st.rdata[COUNT_WIDTH-1:0] = st.count;
						next_st.rdata[tpcp_pkg::ACTIVE_LSB +: INPUT_COUNT] = cond_bus.active;
					end
					tpcp_pkg::OFF_IRQ_STATUS: begin
						next_st.rdata[tpcp_pkg::IRQ_WIDTH-1:0] = st.irq_status;
					end
					tpcp_pkg::OFF_IRQ_MASK: begin
						next_st.rdata[tpcp_pkg::IRQ_WIDTH-1:0] = st.irq_mask;
					end
					default: begin
						next_st.rdata = '0;
					end
				endcase
			end
		end

		// Register writes take effect at the edge that ends the cycle with waitrequest low
		if (accept && i_avs_write) begin
			unique case (i_avs_address)
				tpcp_pkg::OFF_HS_MODE: begin
					next_st.hs_mode = 1'(tpcp_merge(32'(st.hs_mode), i_avs_writedata,
						i_avs_byteenable)); // [RULE_01]
				end
				tpcp_pkg::OFF_SET_COUNT: begin
					next_st.set_count = COUNT_WIDTH'(tpcp_merge(32'(st.set_count),
						i_avs_writedata, i_avs_byteenable));
				end
				tpcp_pkg::OFF_SPEC_COUNT: begin
					next_st.spec_count = COUNT_WIDTH'(tpcp_merge(32'(st.spec_count),
						i_avs_writedata, i_avs_byteenable));
				end
				tpcp_pkg::OFF_POLARITY: begin
					next_st.polarity = INPUT_COUNT'(tpcp_merge(32'(st.polarity),
						i_avs_writedata, i_avs_byteenable)); // [RULE_04]
				end
				tpcp_pkg::OFF_TRIG_SEL: begin
					next_st.trig_sel = tpcp_pkg::TRIG_SEL_WIDTH'(tpcp_merge(32'(st.trig_sel),
						i_avs_writedata, i_avs_byteenable));
				end
				tpcp_pkg::OFF_IRQ_MASK: begin
					next_st.irq_mask = tpcp_pkg::IRQ_WIDTH'(tpcp_merge(32'(st.irq_mask),
						i_avs_writedata, i_avs_byteenable));
				end
				default: begin
					next_st.irq_mask = st.irq_mask;
				end
			endcase
		end

		// Sticky status: a new event wins over the read clear
		next_st.irq_status = (st.irq_status & ~status_clr) | events;
		next_st.irq = |(next_st.irq_status & next_st.irq_mask);
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st <= '0;
			st.hs_mode <= tpcp_pkg::HS_MODE_RESET;
			st.set_count <= COUNT_WIDTH'(tpcp_pkg::SET_COUNT_RESET);
			st.spec_count <= COUNT_WIDTH'(tpcp_pkg::SPEC_COUNT_RESET);
			st.polarity <= INPUT_COUNT'(tpcp_pkg::POLARITY_RESET);
			st.trig_sel <= tpcp_pkg::TRIG_SEL_RESET;
			st.irq_mask <= tpcp_pkg::IRQ_MASK_RESET;
			st.waitreq <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign o_avs_readdata = st.rdata;
	assign o_avs_waitrequest = st.waitreq;
	assign o_first_switch_output = st.set_ind;
	assign o_high_speed_output_terminal = st.hs_out;
	assign o_irq = st.irq;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_pulse_at_set;
		cond_bus.count_pulse && (st.set_count != '0) && (cnt_inc == st.set_count);
	endsequence

	sequence s_set_indicated;
		st.set_ind && (st.count == '0);
	endsequence

	sequence s_pulse_at_spec;
		cond_bus.count_pulse && (st.spec_count != '0) && (cnt_inc == st.spec_count);
	endsequence

	a_hs_switch_mode: assert property ($past(st.hs_mode) == tpcp_pkg::HS_MODE_SWITCH |-> // [RULE_01]
		o_high_speed_output_terminal == st.spec_ind) else $error("switch mode output wrong");
	a_hs_pulse_mode: assert property ($past(st.hs_mode) == tpcp_pkg::HS_MODE_PULSE |-> // [RULE_01]
		o_high_speed_output_terminal == $past(cond_bus.count_pulse))
		else $error("pulse mode output wrong");
	a_set_reached: assert property (s_pulse_at_set |=> s_set_indicated ##1 // [RULE_02]
		(o_first_switch_output || $past(cond_bus.count_pulse)))
		else $error("set count arrival not indicated");
	a_count_restart: assert property (s_pulse_at_set |=> // [RULE_08]
		st.count == '0 && o_first_switch_output)
		else $error("count did not restart");
	a_count_step: assert property (cond_bus.count_pulse && !set_hit |=> // [RULE_02]
		st.count == $past(cnt_inc) && !o_first_switch_output) else $error("count step wrong");
	a_count_idle: assert property (!cond_bus.count_pulse |=> $stable(st.count) && $stable(st.set_ind))
		else $error("count moved without pulse");
	a_spec_reached: assert property (s_pulse_at_spec |=> st.spec_ind) // [RULE_03]
		else $error("specified count arrival not indicated");
	a_spec_hold: assert property (st.spec_ind && st.count != '0 |=> st.spec_ind) // [RULE_03]
		else $error("specified indication dropped before set count");
	a_spec_drop: assert property (st.spec_ind && st.count == '0 && cond_bus.count_pulse && // [RULE_03]
		!spec_hit |=> !st.spec_ind) else $error("specified indication not released");
	a_bus_answer: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest ##1
		o_avs_waitrequest) else $error("bus answer timing wrong");
	a_irq_level: assert property (o_irq == $past(|(next_st.irq_status & next_st.irq_mask)))
		else $error("interrupt level wrong");
endmodule : tpcp_top
`default_nettype wire

// ===== tpcp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tpcp_top_tb;
	logic i_clk, i_rst_n, rd, wr, go, irq, sw, hs, wq;
	logic [4:0] addr, pol, rest, raw;
	logic [31:0] wdata, rdata, lfsr_s;
	logic [2:0] sel;
	int failures = 0, checks = 0, m_cnt = 0, m_stat = 0, hs_cnt = 0;
	logic m_set_i = 0, m_spec_i = 0;

	tpcp_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wq), .i_digital_input(raw),
		.o_first_switch_output(sw), .o_high_speed_output_terminal(hs), .o_irq(irq));
	tpcp_contacts far (.i_clk(i_clk), .i_go(go), .i_sel(sel), .i_pol(pol), .i_rest(rest),
		.o_raw(raw));

	initial begin
		i_clk = 0;
		forever #20 i_clk = ~i_clk;
	end
	always @(negedge i_clk) if (hs === 1'b1) hs_cnt++;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		// Sampled at the rising edge, before the design's own updates land
		do begin
			@(posedge i_clk);
			n++;
		end while (wq !== 1'b0 && n < 50);
		if (n >= 50) begin
			failures++;
			end_of_test();
		end
		q = rdata;
		rd <= 0;
		wr <= 0;
	endtask : bus

	task automatic wreg(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1, a, d, q);
	endtask : wreg

	task automatic rreg(input logic [4:0] a, input string name, input logic [31:0] exp);
		logic [31:0] q;
		bus(0, a, 0, q);
		check(name, q, exp);
	endtask : rreg

	task automatic run_count(input int set, input int spec, input logic mode, input int n);
		logic [2:0] s;
		lfsr_s = lfsr(lfsr_s);
		s = 3'(lfsr_s % 5);
		wreg(tpcp_pkg::OFF_TRIG_SEL, 32'h5);
		pol <= lfsr_s[4:0];
		rest <= ~lfsr_s[4:0];
		sel <= s;
		wreg(tpcp_pkg::OFF_POLARITY, {27'h0, lfsr_s[4:0]});
		wreg(tpcp_pkg::OFF_SET_COUNT, set);
		wreg(tpcp_pkg::OFF_SPEC_COUNT, spec);
		wreg(tpcp_pkg::OFF_HS_MODE, {31'h0, mode});
		wreg(tpcp_pkg::OFF_IRQ_MASK, {30'h0, lfsr_s[9:8]});
		wreg(tpcp_pkg::OFF_TRIG_SEL, {29'h0, s});
		hs_cnt = 0;
		repeat (n) begin
			@(posedge i_clk) go <= 1;
			@(posedge i_clk) go <= 0;
			repeat (8) @(posedge i_clk);
			m_set_i = (set != 0 && m_cnt + 1 == set);
			if (spec != 0 && spec <= set && m_cnt + 1 == spec) m_spec_i = 1;
			else if (m_cnt + 1 == 1) m_spec_i = 0;
			m_stat |= {m_spec_i && m_cnt + 1 == spec, m_set_i};
			m_cnt = m_set_i ? 0 : (m_cnt + 1) % 65536;
			@(negedge i_clk);
			check("set ind", sw, m_set_i);
			if (!mode) check("spec ind", hs, m_spec_i);
			check("irq", irq, 32'((m_stat & lfsr_s[9:8]) != 0));
			rreg(tpcp_pkg::OFF_COUNT, "count", m_cnt);
		end
		if (mode) check("hs pulses", hs_cnt, n);
		rreg(tpcp_pkg::OFF_IRQ_STATUS, "status", m_stat);
		m_stat = 0;
		repeat (2) @(negedge i_clk);
		check("irq clear", irq, 0);
		$display("test count set %0d spec %0d mode %0d done", set, spec, mode);
	endtask : run_count

	initial begin
		repeat (20000) @(posedge i_clk);
		failures++;
		end_of_test();
	end

	initial begin
		logic [4:0] p, r;
		i_rst_n = 0;
		rd = 0;
		wr = 0;
		addr = 0;
		wdata = 0;
		go = 0;
		sel = 0;
		pol = 5'h1F;
		rest = 0;
		lfsr_s = 32'hce7f61a3;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1;
		rreg(tpcp_pkg::OFF_HS_MODE, "mode rst", 0);
		rreg(tpcp_pkg::OFF_SET_COUNT, "set rst", 0);
		rreg(tpcp_pkg::OFF_SPEC_COUNT, "spec rst", 0);
		rreg(tpcp_pkg::OFF_POLARITY, "pol rst", 32'(tpcp_pkg::POLARITY_RESET));
		rreg(tpcp_pkg::OFF_IRQ_MASK, "mask rst", 0);
		wreg(tpcp_pkg::OFF_COUNT, 32'hFFFF);
		rreg(tpcp_pkg::OFF_COUNT, "count ro", 0);
		rreg(5'h02, "unmapped", 0);
		$display("test reset done");
		wreg(tpcp_pkg::OFF_TRIG_SEL, 32'h5);
		repeat (8) begin
			lfsr_s = lfsr(lfsr_s);
			p = lfsr_s[4:0];
			r = lfsr_s[12:8];
			rest <= r;
			wreg(tpcp_pkg::OFF_POLARITY, {27'h0, p});
			rreg(tpcp_pkg::OFF_POLARITY, "pol", {27'h0, p});
			rreg(tpcp_pkg::OFF_COUNT, "active", {11'h0, ~(r ^ p), 16'h0});
		end
		$display("test polarity done");
		run_count(3, 2, 0, 6);
		run_count(8, 5, 0, 8);
		run_count(4, 6, 0, 4);
		run_count(2, 2, 1, 4);
		end_of_test();
	end
endmodule : tpcp_top_tb
`default_nettype wire
